// file: verilog/tld_cfg.sv
// Purpose: Torque limit selection, homing hold timing, display and
//          monitor settings, and divider output shaping.
// Assumes: Avalon-MM slave with byte addresses; peer inputs on clock.
// Notes:   Restart settings are copied after reset or restart command.
//
// Overview of operation
// - Selector picks limit sources, zero to two
// - Effective limit is minimum with maximum torque
// - Second limit 0..500, default 300, clamped
// - Display selector 0..42, default 34, restart
// - Homing advances after torque holds for threshold
// - Hold time used only for methods -6..-1
// - Polarity bit 0 inverts Z output
// - Bit 1 inverts A only in comparison
// - Bit 2 inverts B only in comparison
// - Polarity 0..7, default 0, restart
// - Zero width gives one A/B cycle Z
// - Width adds microseconds, latched at restart
`timescale 1ns/1ps
module tld_cfg import tld_pkg::*; #(
  parameter int CYC_MS = CYC_PER_MS,
  parameter int ZCW    = 24
) (
  // Clock and reset
  input  wire logic          clock,
  input  wire logic          rst,
  // Avalon-MM slave
  input  wire logic [AW-1:0] address,
  input  wire logic          read,
  input  wire logic          write,
  input  wire logic [DW-1:0] writedata,
  input  wire logic [3:0]    byteenable,
  output logic [DW-1:0]      readdata,
  output logic               waitrequest,
  // Drive state
  input  wire logic [15:0]   motor_torque,
  input  wire logic          homing_active,
  input  wire logic [7:0]    homing_method,
  // Divider phases in
  input  wire logic          div_a_in,
  input  wire logic          div_b_in,
  input  wire logic          div_z_in,
  input  wire logic          cmp_active,
  // Torque limits out
  output tld_limits_s        limits,
  output logic               homing_advance,
  // Display and monitor
  output logic [15:0]        display_select,
  output logic [15:0]        mon_index,
  output logic [3:0]         mon_subindex,
  // Divider phases out
  output logic               div_a_out,
  output logic               div_b_out,
  output logic               div_z_out
);

  logic [15:0]  first_tl_q;
  logic [15:0]  sel_q;
  logic [15:0]  second_tl_q;
  logic [15:0]  disp_q;
  logic [15:0]  hold_q;
  logic [15:0]  third_tl_q;
  logic [19:0]  mon_q;
  logic [15:0]  pol_q;
  logic [15:0]  zw_q;
  logic [15:0]  max_tq_q;
  logic [15:0]  pos_obj_q;
  logic [15:0]  neg_obj_q;
  tld_restart_s act_q;
  logic         copy_q;
  logic         restart_req;
  logic         adv_pulse;
  logic         z_shaped;
  logic         hm_torque;
  logic         at_limit;
  logic [15:0]  abs_tq;
  logic [15:0]  hm_lim;
  logic [15:0]  index;
  logic         bus_go;
  logic         do_wr;
  logic [31:0]  wval;

  function automatic logic [15:0] sat(
    input logic [31:0] v,
    input logic [15:0] mx
  );
    sat = (v > {16'h0000, mx}) ? mx : v[15:0];
  endfunction

  function automatic logic [15:0] min16(
    input logic [15:0] x,
    input logic [15:0] y
  );
    min16 = (x < y) ? x : y;
  endfunction

  // Bus decode; unmapped words read as zero and ignore writes.
  assign index  = address[17:2];
  assign bus_go = (read || write) && waitrequest;
  assign do_wr  = write && !waitrequest;

  always_comb begin
    wval = '0;
    for (int i = 0; i < 4; i++) begin
      if (byteenable[i]) begin
        wval[8*i +: 8] = writedata[8*i +: 8];
      end
    end
  end

  // One wait state: the request is taken at the second edge.
  always_ff @(posedge clock) begin
    if (rst) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= !bus_go;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      readdata <= '0;
    end else if (bus_go && read) begin
      case (index)
        IDX_FIRST_TL:  readdata <= {16'h0000, first_tl_q};
        IDX_TL_SEL:    readdata <= {16'h0000, sel_q};
        IDX_SECOND_TL: readdata <= {16'h0000, second_tl_q};
        IDX_DISP_SEL:  readdata <= {16'h0000, disp_q};
        IDX_HOLD_TIME: readdata <= {16'h0000, hold_q};
        IDX_THIRD_TL:  readdata <= {16'h0000, third_tl_q};
        IDX_MON_WORD:  readdata <= {12'h000, mon_q};
        IDX_DIV_POL:   readdata <= {16'h0000, pol_q};
        IDX_Z_WIDTH:   readdata <= {16'h0000, zw_q};
        IDX_MAX_TQ:    readdata <= {16'h0000, max_tq_q};
        IDX_POS_OBJ:   readdata <= {16'h0000, pos_obj_q};
        IDX_NEG_OBJ:   readdata <= {16'h0000, neg_obj_q};
        IDX_STATUS:    readdata <= {limits.pos, limits.neg};
        IDX_RESTART:   readdata <= {4'h0, act_q};
        default:       readdata <= '0;
      endcase
    end
  end

  // Limit settings act immediately.
  always_ff @(posedge clock) begin
    if (rst) begin
      first_tl_q  <= RST_FIRST_TL;
      sel_q       <= RST_TL_SEL;
      second_tl_q <= RST_SECOND_TL;
      third_tl_q  <= RST_THIRD_TL;
      hold_q      <= RST_HOLD_TIME;
      max_tq_q    <= RST_MAX_TQ;
      pos_obj_q   <= RST_OBJ_TL;
      neg_obj_q   <= RST_OBJ_TL;
    end else if (do_wr) begin
      case (index)
        IDX_FIRST_TL:  first_tl_q  <= sat(wval, MAX_TQ_PCT);
        IDX_TL_SEL:    sel_q       <= sat(wval, MAX_SEL);
        IDX_SECOND_TL: second_tl_q <= sat(wval, MAX_TQ_PCT);
        IDX_THIRD_TL:  third_tl_q  <= sat(wval, MAX_TQ_PCT);
        IDX_HOLD_TIME: hold_q      <= sat(wval, MAX_HOLD);
        IDX_MAX_TQ:    max_tq_q    <= sat(wval, MAX_TQ_PCT);
        IDX_POS_OBJ:   pos_obj_q   <= sat(wval, MAX_TQ_PCT);
        IDX_NEG_OBJ:   neg_obj_q   <= sat(wval, MAX_TQ_PCT);
        default:       first_tl_q  <= first_tl_q;
      endcase
    end
  end

  // Stored values here only reach the logic through the active copy.
  always_ff @(posedge clock) begin
    if (rst) begin
      disp_q <= RST_DISP_SEL;
      pol_q  <= RST_DIV_POL;
      zw_q   <= RST_Z_WIDTH;
    end else if (do_wr) begin
      case (index)
        IDX_DISP_SEL: disp_q <= sat(wval, MAX_DISP);
        IDX_DIV_POL:  pol_q  <= sat(wval, MAX_POL);
        IDX_Z_WIDTH:  zw_q   <= sat(wval, MAX_ZW);
        default:      disp_q <= disp_q;
      endcase
    end
  end

  // Monitor word applies immediately.
  always_ff @(posedge clock) begin
    if (rst) begin
      mon_q <= RST_MON_WORD;
    end else if (do_wr && index == IDX_MON_WORD) begin
      mon_q <= wval[19:0];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      mon_index    <= '0;
      mon_subindex <= '0;
    end else begin
      mon_index    <= mon_q[19:4];
      mon_subindex <= mon_q[3:0];
    end
  end

  // Restart settings are copied in the cycle after reset release and
  // again on a software restart; writes meanwhile stay pending.
  assign restart_req = do_wr && index == IDX_RESTART
                       && wval[RST_CMD_BIT];

  always_ff @(posedge clock) begin
    if (rst) begin
      copy_q <= 1'b1;
    end else begin
      copy_q <= restart_req;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      act_q.disp <= RST_DISP_SEL;
      act_q.pol  <= RST_DIV_POL[2:0];
      act_q.zw   <= RST_Z_WIDTH[8:0];
    end else if (copy_q) begin
      act_q.disp <= disp_q;
      act_q.pol  <= pol_q[2:0];
      act_q.zw   <= zw_q[8:0];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      display_select <= RST_DISP_SEL;
    end else begin
      display_select <= act_q.disp;
    end
  end

  // Torque homing detection.
  assign hm_torque = homing_active
                     && $signed(homing_method) >= HM_TQ_LO
                     && $signed(homing_method) <= HM_TQ_HI;
  assign hm_lim = min16(third_tl_q, max_tq_q);
  assign abs_tq = motor_torque[15] ? (16'h0000 - motor_torque)
                                   : motor_torque;
  assign at_limit = abs_tq >= hm_lim;

  always_ff @(posedge clock) begin
    if (rst) begin
      limits <= '0;
    end else if (hm_torque) begin
      limits.pos <= hm_lim;
      limits.neg <= hm_lim;
    end else begin
      case (sel_q)
        SEL_SAME: begin
          limits.pos <= min16(first_tl_q, max_tq_q);
          limits.neg <= min16(first_tl_q, max_tq_q);
        end
        SEL_SPLIT: begin
          limits.pos <= min16(first_tl_q, max_tq_q);
          limits.neg <= min16(second_tl_q, max_tq_q);
        end
        default: begin
          limits.pos <= min16(pos_obj_q, max_tq_q);
          limits.neg <= min16(neg_obj_q, max_tq_q);
        end
      endcase
    end
  end

  tld_hold_timer #(
    .CYC_MS (CYC_MS)
  ) u_hold (
    .clock     (clock),
    .rst       (rst),
    .enable    (hm_torque),
    .at_limit  (at_limit),
    .thresh_ms (hold_q),
    .advance   (adv_pulse)
  );

  always_ff @(posedge clock) begin
    if (rst) begin
      homing_advance <= 1'b0;
    end else begin
      homing_advance <= adv_pulse;
    end
  end

  tld_z_stretch #(
    .CW (ZCW)
  ) u_z (
    .clock    (clock),
    .rst      (rst),
    .a_in     (div_a_in),
    .z_in     (div_z_in),
    .width_us (act_q.zw),
    .z_out    (z_shaped)
  );

  // Divider phases with polarity applied.
  always_ff @(posedge clock) begin
    if (rst) begin
      div_a_out <= 1'b0;
      div_b_out <= 1'b0;
      div_z_out <= 1'b0;
    end else begin
      div_a_out <= div_a_in ^ (cmp_active && act_q.pol[POL_A]);
      div_b_out <= div_b_in ^ (cmp_active && act_q.pol[POL_B]);
      div_z_out <= z_shaped ^ act_q.pol[POL_Z];
    end
  end

endmodule

// file: shared/tld_pkg.sv
// Purpose: Shared constants and types for the torque limit and divider
//          output configuration block.
// Assumes: 40 MHz clock; register indices map to byte address index*4.
// Notes:   Ranges saturate on write.
package tld_pkg;

  localparam int CLK_HZ    = 40_000_000;
  localparam int US_PER_S  = 1_000_000;
  localparam int MS_PER_S  = 1_000;
  localparam int CYC_PER_US = CLK_HZ / US_PER_S;
  localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;

  localparam int AW = 18;
  localparam int DW = 32;

  // Register indices; byte address is index * 4.
  localparam logic [15:0] IDX_FIRST_TL  = 16'h2013;
  localparam logic [15:0] IDX_TL_SEL    = 16'h2521;
  localparam logic [15:0] IDX_SECOND_TL = 16'h2522;
  localparam logic [15:0] IDX_DISP_SEL  = 16'h2528;
  localparam logic [15:0] IDX_HOLD_TIME = 16'h2537;
  localparam logic [15:0] IDX_THIRD_TL  = 16'h2539;
  localparam logic [15:0] IDX_MON_WORD  = 16'h2540;
  localparam logic [15:0] IDX_DIV_POL   = 16'h2542;
  localparam logic [15:0] IDX_Z_WIDTH   = 16'h2543;
  localparam logic [15:0] IDX_STATUS    = 16'h2600;
  localparam logic [15:0] IDX_RESTART   = 16'h2601;
  localparam logic [15:0] IDX_MAX_TQ    = 16'h6072;
  localparam logic [15:0] IDX_POS_OBJ   = 16'h60e0;
  localparam logic [15:0] IDX_NEG_OBJ   = 16'h60e1;

  // Reset values.
  localparam logic [15:0] RST_FIRST_TL  = 16'h012c;
  localparam logic [15:0] RST_TL_SEL    = 16'h0002;
  localparam logic [15:0] RST_SECOND_TL = 16'h012c;
  localparam logic [15:0] RST_DISP_SEL  = 16'h0022;
  localparam logic [15:0] RST_HOLD_TIME = 16'h01f4;
  localparam logic [15:0] RST_THIRD_TL  = 16'h0050;
  localparam logic [19:0] RST_MON_WORD  = 20'h00000;
  localparam logic [15:0] RST_DIV_POL   = 16'h0000;
  localparam logic [15:0] RST_Z_WIDTH   = 16'h0000;
  localparam logic [15:0] RST_MAX_TQ    = 16'h012c;
  localparam logic [15:0] RST_OBJ_TL    = 16'h012c;

  // Upper bounds of each setting.
  localparam logic [15:0] MAX_TQ_PCT = 16'h01f4;
  localparam logic [15:0] MAX_SEL    = 16'h0002;
  localparam logic [15:0] MAX_DISP   = 16'h002a;
  localparam logic [15:0] MAX_HOLD   = 16'h1388;
  localparam logic [15:0] MAX_POL    = 16'h0007;
  localparam logic [15:0] MAX_ZW     = 16'h01f4;

  localparam logic [15:0] SEL_SAME   = 16'h0000;
  localparam logic [15:0] SEL_SPLIT  = 16'h0001;
  localparam logic [15:0] SEL_OBJ    = 16'h0002;

  localparam logic signed [7:0] HM_TQ_LO = -8'sd6;
  localparam logic signed [7:0] HM_TQ_HI = -8'sd1;

  // Field positions.
  localparam int POL_Z = 0;
  localparam int POL_A = 1;
  localparam int POL_B = 2;
  localparam int RST_CMD_BIT = 0;

  typedef struct packed {
    logic [15:0] disp;
    logic [2:0]  pol;
    logic [8:0]  zw;
  } tld_restart_s;

  typedef struct packed {
    logic [15:0] pos;
    logic [15:0] neg;
  } tld_limits_s;

endpackage

// file: verilog/tld_hold_timer.sv
// Purpose: Times how long torque stays at the homing limit.
// Assumes: Inputs come from logic on the same clock.
// Notes:   One advance pulse per stay at the limit.
`timescale 1ns/1ps
module tld_hold_timer import tld_pkg::*; #(
  parameter int CYC_MS = CYC_PER_MS
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Control
  input  wire logic        enable,
  input  wire logic        at_limit,
  input  wire logic [15:0] thresh_ms,
  // Result
  output logic             advance
);

  logic [31:0] cyc_q;
  logic [15:0] ms_q;
  logic        done_q;
  logic        run;

  assign run = enable && at_limit;

  always_ff @(posedge clock) begin
    if (rst || !run) begin
      cyc_q <= '0;
      ms_q  <= '0;
    end else if (cyc_q == 32'(CYC_MS - 1)) begin
      cyc_q <= '0;
      if (ms_q != MAX_HOLD) begin
        ms_q <= ms_q + 16'h0001;
      end
    end else begin
      cyc_q <= cyc_q + 32'h1;
    end
  end

  // Leaving the limit rearms, so a fresh stay must last the full time.
  always_ff @(posedge clock) begin
    if (rst || !run) begin
      done_q  <= 1'b0;
      advance <= 1'b0;
    end else begin
      advance <= !done_q && (ms_q >= thresh_ms);
      if (ms_q >= thresh_ms) begin
        done_q <= 1'b1;
      end
    end
  end

endmodule

// file: verilog/tld_z_stretch.sv
// Purpose: Sets the divider Z pulse length from the A/B cycle.
// Assumes: A and Z arrive from divider logic on the same clock.
// Notes:   The A/B cycle is the last measured A rise to A rise time.
`timescale 1ns/1ps
module tld_z_stretch import tld_pkg::*; #(
  parameter int CW = 24
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Divider phases
  input  wire logic        a_in,
  input  wire logic        z_in,
  input  wire logic [8:0]  width_us,
  // Shaped Z
  output logic             z_out
);

  logic [CW-1:0] per_cnt_q;
  logic [CW-1:0] period_q;
  logic [CW-1:0] left_q;
  logic          a_d_q;
  logic          z_d_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      a_d_q     <= 1'b0;
      per_cnt_q <= '0;
      period_q  <= '0;
    end else begin
      a_d_q <= a_in;
      if (a_in && !a_d_q) begin
        period_q  <= per_cnt_q + CW'(1);
        per_cnt_q <= '0;
      end else if (per_cnt_q != '1) begin
        per_cnt_q <= per_cnt_q + CW'(1);
      end
    end
  end

  // Width zero gives exactly one A/B cycle; otherwise it adds on top.
  always_ff @(posedge clock) begin
    if (rst) begin
      z_d_q  <= 1'b0;
      left_q <= '0;
      z_out  <= 1'b0;
    end else begin
      z_d_q <= z_in;
      if (z_in && !z_d_q) begin
        left_q <= period_q + CW'(width_us) * CW'(CYC_PER_US);
        z_out  <= 1'b1;
      end else if (left_q > CW'(1)) begin
        left_q <= left_q - CW'(1);
      end else begin
        left_q <= '0;
        z_out  <= 1'b0;
      end
    end
  end

endmodule

// file: verif/tld_host_rx.sv
// Purpose: Host side receiver of the emulated encoder Z output.
// Assumes: Z arrives on the drive clock, active high.
// Notes:   Reports the length of each completed high run in cycles.
`timescale 1ns/1ps
module tld_host_rx (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // Divider phase
  input  wire logic z,
  // Last pulse
  output logic [15:0] width_q,
  output logic [7:0]  count_q
);
  logic [15:0] run_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      run_q   <= 16'h0;
      width_q <= 16'h0;
      count_q <= 8'h0;
    end else if (z) begin
      run_q <= run_q + 16'h1;
    end else if (run_q != 16'h0) begin
      width_q <= run_q;
      count_q <= count_q + 8'h1;
      run_q   <= 16'h0;
    end
  end
endmodule

// file: verif/tld_cfg_chk.sv
// Purpose: Port level assertions for the torque and divider block.
// Assumes: Register index sits in address bits 17:2; byteenable full.
// Notes:   Shadows track only what the properties need.
`timescale 1ns/1ps
module tld_cfg_chk import tld_pkg::*; (
  // Clock and reset
  input wire logic          clock,
  input wire logic          rst,
  // Register bus
  input wire logic [AW-1:0] address,
  input wire logic          read,
  input wire logic          write,
  input wire logic [DW-1:0] writedata,
  input wire logic          waitrequest,
  // Drive state
  input wire logic          homing_active,
  input wire logic [7:0]    homing_method,
  input wire logic          div_a_in,
  input wire logic          div_b_in,
  input wire logic          cmp_active,
  // Outputs
  input wire tld_limits_s   limits,
  input wire logic          homing_advance,
  input wire logic [15:0]   display_select,
  input wire logic [15:0]   mon_index,
  input wire logic [3:0]    mon_subindex,
  input wire logic          div_a_out,
  input wire logic          div_b_out
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  logic        acc;
  logic        tq_hm;
  logic [15:0] max_q;
  logic [19:0] mon_q;
  logic [2:0]  rs_q;

  assign acc   = write && !waitrequest;
  assign tq_hm = homing_active && $signed(homing_method) >= HM_TQ_LO &&
                 $signed(homing_method) <= HM_TQ_HI;

  always_ff @(posedge clock) begin
    if (rst) max_q <= RST_MAX_TQ;
    else if (acc && address[17:2] == IDX_MAX_TQ) max_q <= writedata[15:0];
  end

  always_ff @(posedge clock) begin
    if (rst) mon_q <= RST_MON_WORD;
    else if (acc && address[17:2] == IDX_MON_WORD) mon_q <= writedata[19:0];
  end

  // A restart copy may move the display item for a few cycles only.
  always_ff @(posedge clock) begin
    if (rst) rs_q <= 3'h0;
    else if (acc && address[17:2] == IDX_RESTART) rs_q <= 3'h0;
    else if (rs_q != 3'h7) rs_q <= rs_q + 3'h1;
  end

  sequence reg_wr(idx);
    write && !waitrequest && address[17:2] == idx;
  endsequence

  a_bus_answer: assert property ($rose(read || write) |=> !waitrequest)
    else $error("bus answer late");
  a_pos_capped:
    assert property ($past(!rst) |-> limits.pos <= $past(max_q))
    else $error("positive limit above maximum torque");
  a_neg_capped:
    assert property ($past(!rst) |-> limits.neg <= $past(max_q))
    else $error("negative limit above maximum torque");
  a_homing_same:
    assert property (tq_hm && $past(tq_hm) |-> limits.pos == limits.neg)
    else $error("homing limits differ");
  a_adv_cause:
    assert property (homing_advance |-> $past(tq_hm, 2))
    else $error("advance outside torque homing");
  a_adv_pulse:
    assert property (homing_advance |=> !homing_advance)
    else $error("advance longer than one cycle");
  a_disp_frozen:
    assert property (rs_q == 3'h7 |=> $stable(display_select))
    else $error("display item moved without restart");
  a_disp_range:
    assert property (display_select <= MAX_DISP)
    else $error("display item out of range");
  a_mon_split:
    assert property (reg_wr(IDX_MON_WORD) |->
                     ##[1:2] ({mon_index, mon_subindex} == mon_q))
    else $error("monitor word split wrong");
  a_ab_plain:
    assert property ($past(!cmp_active) && $past(!rst) |->
      div_a_out == $past(div_a_in) && div_b_out == $past(div_b_in))
    else $error("phase A or B inverted outside comparison");
endmodule

bind tld_cfg tld_cfg_chk i_tld_cfg_chk (
  .clock(clock), .rst(rst), .address(address), .read(read),
  .write(write), .writedata(writedata), .waitrequest(waitrequest),
  .homing_active(homing_active), .homing_method(homing_method),
  .div_a_in(div_a_in), .div_b_in(div_b_in), .cmp_active(cmp_active),
  .limits(limits), .homing_advance(homing_advance),
  .display_select(display_select), .mon_index(mon_index),
  .mon_subindex(mon_subindex), .div_a_out(div_a_out),
  .div_b_out(div_b_out)
);

// file: verif/tld_cfg_test.sv
// Purpose: Self checking bench for the torque and divider block.
// Assumes: Hold timer shortened to 10 cycles per millisecond.
// Notes:   Phase A runs with an 8 cycle period during Z checks.
`timescale 1ns/1ps
module tld_cfg_test import tld_pkg::*;;
  logic          clock = 1'b0;
  logic          rst = 1'b1;
  logic [AW-1:0] address = '0;
  logic          read = 1'b0;
  logic          write = 1'b0;
  logic [DW-1:0] writedata = '0;
  logic [DW-1:0] readdata;
  logic          waitrequest;
  logic [15:0]   motor_torque = '0;
  logic          homing_active = 1'b0;
  logic [7:0]    homing_method = '0;
  logic          run_ab = 1'b0;
  logic          a_lvl = 1'b0;
  logic          b_lvl = 1'b0;
  logic          div_z_in = 1'b0;
  logic          cmp_active = 1'b0;
  logic [2:0]    ph_q = '0;
  logic          div_a_in;
  logic          div_b_in;
  tld_limits_s   limits;
  logic          homing_advance;
  logic [15:0]   display_select;
  logic [15:0]   mon_index;
  logic [3:0]    mon_subindex;
  logic          div_a_out;
  logic          div_b_out;
  logic          div_z_out;
  logic [15:0]   z_width;
  logic [7:0]    z_count;
  int            mismatches = 0;
  int            compares = 0;
  int            cycles = 0;
  int            n;

  always #12.5 clock = ~clock;
  always @(posedge clock) ph_q <= ph_q + 3'h1;
  assign div_a_in = run_ab ? ph_q[2] : a_lvl;
  assign div_b_in = run_ab ? ph_q[2] ^ ph_q[1] : b_lvl;

  tld_cfg #(.CYC_MS(10)) i_tld_cfg (
    .clock(clock), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(4'hf),
    .readdata(readdata), .waitrequest(waitrequest),
    .motor_torque(motor_torque), .homing_active(homing_active),
    .homing_method(homing_method), .div_a_in(div_a_in),
    .div_b_in(div_b_in), .div_z_in(div_z_in), .cmp_active(cmp_active),
    .limits(limits), .homing_advance(homing_advance),
    .display_select(display_select), .mon_index(mon_index),
    .mon_subindex(mon_subindex), .div_a_out(div_a_out),
    .div_b_out(div_b_out), .div_z_out(div_z_out)
  );

  tld_host_rx i_tld_host_rx (
    .clock(clock), .rst(rst), .z(div_z_out), .width_q(z_width),
    .count_q(z_count)
  );

  task automatic conclude;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      conclude();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic access(input logic wr, input logic [15:0] idx,
                        input logic [31:0] d, output logic [31:0] q);
    @(posedge clock);
    address   <= {idx, 2'b00};
    writedata <= d;
    write     <= wr;
    read      <= !wr;
    do @(posedge clock); while (waitrequest !== 1'b0);
    q = readdata;
    write <= 1'b0;
    read  <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    logic [31:0] q;
    access(1'b1, idx, d, q);
  endtask

  task automatic rd(input string what, input logic [15:0] idx,
                    input logic [31:0] exp);
    logic [31:0] q;
    access(1'b0, idx, '0, q);
    chk(what, exp, q);
  endtask

  task automatic wait_cyc(input int k);
    repeat (k) @(posedge clock);
  endtask

  task automatic lim_chk(input logic [31:0] exp);
    wait_cyc(2);
    chk("limits", exp, limits);
  endtask

  task automatic restart;
    wr(IDX_RESTART, 32'h1);
    wait_cyc(4);
  endtask

  // Counts advance pulses over a fixed window.
  task automatic pulses(input int k);
    n = 0;
    repeat (k) begin
      @(posedge clock);
      if (homing_advance === 1'b1) n++;
    end
  endtask

  task automatic z_pulse(input logic [15:0] exp);
    logic [7:0] c0;
    int         k;
    c0 = z_count;
    @(posedge clock);
    div_z_in <= 1'b1;
    @(posedge clock);
    div_z_in <= 1'b0;
    k = 0;
    while (z_count === c0 && k < 400) begin
      @(posedge clock);
      k++;
    end
    chk("z count", {24'h0, c0 + 8'h1}, {24'h0, z_count});
    chk("z width", {16'h0, exp}, {16'h0, z_width});
  endtask

  initial begin
    wait_cyc(2);
    rst <= 1'b0;
    rd("second limit", IDX_SECOND_TL, 32'h12c);
    rd("display select", IDX_DISP_SEL, 32'h22);
    rd("hold time", IDX_HOLD_TIME, 32'h1f4);
    rd("third limit", IDX_THIRD_TL, 32'h50);
    rd("polarity", IDX_DIV_POL, 32'h0);
    rd("z width", IDX_Z_WIDTH, 32'h0);
    rd("unmapped", 16'h2fff, 32'h0);
    chk("display out", 32'h22, {16'h0, display_select});
    $display("test reset values done");
    wr(IDX_FIRST_TL, 32'h64);
    wr(IDX_SECOND_TL, 32'hc8);
    wr(IDX_TL_SEL, 32'h0);
    lim_chk(32'h0064_0064);
    wr(IDX_TL_SEL, 32'h1);
    lim_chk(32'h0064_00c8);
    wr(IDX_POS_OBJ, 32'h190);
    wr(IDX_NEG_OBJ, 32'h32);
    wr(IDX_TL_SEL, 32'h2);
    lim_chk(32'h012c_0032);
    wr(IDX_MAX_TQ, 32'hfa);
    lim_chk(32'h00fa_0032);
    wr(IDX_SECOND_TL, 32'h1c2);
    wr(IDX_TL_SEL, 32'h1);
    lim_chk(32'h0064_00fa);
    rd("status", IDX_STATUS, 32'h0064_00fa);
    wr(IDX_SECOND_TL, 32'h258);
    rd("second limit", IDX_SECOND_TL, 32'h1f4);
    $display("test torque limits done");
    wr(IDX_DISP_SEL, 32'h5);
    wait_cyc(8);
    chk("display out", 32'h22, {16'h0, display_select});
    restart;
    chk("display out", 32'h5, {16'h0, display_select});
    wr(IDX_DISP_SEL, 32'h32);
    rd("display select", IDX_DISP_SEL, 32'h2a);
    wr(IDX_MON_WORD, 32'h60921);
    wait_cyc(2);
    chk("monitor", 32'h60921, {12'h0, mon_index, mon_subindex});
    $display("test display and monitor done");
    wr(IDX_HOLD_TIME, 32'h2);
    motor_torque  <= 16'h50;
    homing_method <= 8'hfa;
    homing_active <= 1'b1;
    n = 0;
    while (homing_advance !== 1'b1 && n < 200) begin
      @(posedge clock);
      n++;
    end
    chk("advance in window", 32'h1, {31'h0, n >= 20 && n <= 26});
    chk("homing limits", 32'h0050_0050, limits);
    wr(IDX_THIRD_TL, 32'h258);
    lim_chk(32'h00fa_00fa);
    homing_method <= 8'h01;
    motor_torque  <= 16'h0fa;
    pulses(60);
    chk("other method pulses", 32'h0, n);
    chk("other method limits", 32'h0064_00fa, limits);
    homing_method <= 8'hff;
    pulses(60);
    chk("method -1 pulses", 32'h1, n);
    homing_active <= 1'b0;
    $display("test homing done");
    wr(IDX_DIV_POL, 32'h5);
    restart;
    a_lvl <= 1'b1;
    wait_cyc(3);
    chk("ab plain", 32'h2, {30'h0, div_a_out, div_b_out});
    chk("z idle", 32'h1, {31'h0, div_z_out});
    cmp_active <= 1'b1;
    wait_cyc(3);
    chk("ab compare", 32'h3, {30'h0, div_a_out, div_b_out});
    cmp_active <= 1'b0;
    wr(IDX_DIV_POL, 32'h2);
    restart;
    chk("z idle", 32'h0, {31'h0, div_z_out});
    cmp_active <= 1'b1;
    wait_cyc(3);
    chk("a compare", 32'h0, {30'h0, div_a_out, div_b_out});
    cmp_active <= 1'b0;
    $display("test polarity done");
    run_ab <= 1'b1;
    wait_cyc(40);
    z_pulse(16'd8);
    wr(IDX_Z_WIDTH, 32'h1);
    z_pulse(16'd8);
    restart;
    z_pulse(16'd48);
    rd("restart copy", IDX_RESTART, 32'h0002_a401);
    $display("test z width done");
    conclude();
  end
endmodule
